// ===== hw/bms_map.vh
// Constants for the boot mode selector: register offsets, fields, keys, defaults.
// Assumes a plain byte-addressed register port; included by bms_top.v only.
`ifndef BMS_MAP_VH
`define BMS_MAP_VH
// Register byte offsets
`define BMS_OFF_EMU_PIN_CFG   8'h00
`define BMS_OFF_EMU_TBL_LO    8'h04
`define BMS_OFF_EMU_TBL_HI    8'h08
`define BMS_OFF_CTRL          8'h0c
`define BMS_OFF_STATUS        8'h10
`define BMS_OFF_RESULT        8'h14
// Pin configuration word fields
`define BMS_KEY_MSB           31
`define BMS_KEY_LSB           24
`define BMS_KEY_VALUE         8'h5a
`define BMS_PIN_DISABLED      8'hff
// Factory default select pins
`define BMS_DEF_PIN0          8'h54
`define BMS_DEF_PIN1          8'h48
`define BMS_DEF_PIN2          8'hff
// Boot mode numbers
`define BMS_MODE_PARALLEL     4'h0
`define BMS_MODE_UART         4'h1
`define BMS_MODE_CAN          4'h2
`define BMS_MODE_FLASH        4'h3
`define BMS_MODE_WAIT         4'h4
`define BMS_MODE_RAM          4'h5
`define BMS_MODE_SPI          4'h6
`define BMS_MODE_I2C          4'h7
`define BMS_MODE_CANFD        4'h8
// Factory default boot table: index 0..3 = parallel, UART, CAN, flash
`define BMS_DEF_TABLE         64'h0000_0000_0302_0100
// Control register bits
`define BMS_CTRL_START        0
`define BMS_CTRL_LDR_DONE     1
// Settling delay after the pins are switched to digital, in ns
`define BMS_SETTLE_NS         200
`endif

// ===== hw/bms_top.v
// Boot mode selector: picks the boot mode and option after reset and sequences
// the final boot steps. Assumes select pins arrive asynchronously, the OTP words
// and straps are static after reset, and a register master drives the plain port.
//
// Behaviour
// - Ending: watchdog off, bootloader in first context, close RAM window, jump.
// - Factory select pins 84 and 72; 00 parallel, 01 UART, 10 CAN, 11 flash.
// - Mode numbers 0..8: parallel, UART, CAN, flash, wait, RAM, SPI, I2C, CAN-FD.
// - Debugger attached with emulation enabled uses emulation registers, otherwise OTP words.
// - Configuration valid only with key 0x5a in bits 31:24, else defaults.
// - Each byte field names a GPIO 0..254; 0xff disables that pin.
// - Valid key with all pins disabled boots entry zero with no sampling.
// - Unbonded pin 0 or 1 takes its default; unbonded pin 2 is disabled.
// - Index bit order pin 0 low to pin 2 high; disabled pins give zero.
// - Table is 64 bits of eight byte entries, entry n at 8n+7:8n.
// - Entry low nibble is mode number, high nibble is option code.
// - Unsupported mode falls back to wait on the emulation path, flash otherwise.
// - Reachable entries equal two to the number of enabled pins.
// - Peripheral boot modes use the first peripheral instance.
// - Security subsystem starts first and alone releases the CPU reset.
// - Emulation path needs debugger attached and emulation enabled in security config.
// - Analog-mode select is cleared to digital before a pin is sampled.
// - Pins are polled after earlier configuration steps, then the loader runs.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "bms_map.vh"

// Limitations:
//   The bootloaders and the per-option pin tables live elsewhere; this block
//   only publishes the mode and option and sequences the steps around them.
//   GPIO numbers index the pin bank directly, so NGPIO must cover every value
//   that a select field can hold, 0 to 255.
//   Bonding is a static strap; a pin that is bonded but floating still reads.

module bms_top #(
  parameter NGPIO   = 256,
  parameter CLK_MHZ = 25
) (
  input  wire              mclk,
  input  wire              resetn,
  input  wire [NGPIO-1:0]  gpio_in,
  input  wire [NGPIO-1:0]  gpio_bonded,
  input  wire [31:0]       otp_pin_cfg,
  input  wire [31:0]       otp_tbl_lo,
  input  wire [31:0]       otp_tbl_hi,
  input  wire              otp_emu_boot_en,
  input  wire              debugger_attached,
  input  wire              sec_release,
  input  wire [7:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata,
  output reg  [2:0]        analog_mode_select,
  output reg               cpu_reset_n,
  output reg               wdog_enable,
  output reg               loader_run,
  output reg               ram_access_window,
  output reg               app_jump,
  output reg  [3:0]        boot_mode,
  output reg  [3:0]        boot_option,
  output reg               decision_valid
);

  // Settle count; rounds up, never below one cycle
  // The settle time is fixed in ns so a faster clock keeps the same margin;
  // the count must fit eight bits, which bounds CLK_MHZ at about 1275.
  localparam integer SETTLE_CYC_I = (`BMS_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam [7:0]   SETTLE_CYC   = (SETTLE_CYC_I < 1) ? 8'h01 : SETTLE_CYC_I[7:0];

  // Boot sequencer states, in the order they are visited:
  //   HOLD   waits for the security subsystem to let the CPU out of reset
  //   CONFIG waits for software to start the decision, then latches sources
  //   ANALOG switches the used select pins to digital, loads the settle count
  //   SETTLE lets the pad inputs and synchronisers settle before sampling
  //   SAMPLE captures the index once from the synchronised pins
  //   DECODE picks the table entry that the index points at
  //   WDOG   stops the watchdog, publishes the decision, starts the loader
  //   LOADER runs until software reports the bootloader finished
  //   CLOSE  closes the first context's RAM window
  //   JUMP   branches to the application and stays there
  localparam [3:0] S_HOLD   = 4'h0;
  localparam [3:0] S_CONFIG = 4'h1;
  localparam [3:0] S_ANALOG = 4'h2;
  localparam [3:0] S_SETTLE = 4'h3;
  localparam [3:0] S_SAMPLE = 4'h4;
  localparam [3:0] S_DECODE = 4'h5;
  localparam [3:0] S_WDOG   = 4'h6;
  localparam [3:0] S_LOADER = 4'h7;
  localparam [3:0] S_CLOSE  = 4'h8;
  localparam [3:0] S_JUMP   = 4'h9;

  // Mode number recognised by this device
  // Codes 9 to 15 are unsupported and take the fallback path
  function supported;
    input [3:0] m;
    begin
      supported = (m <= `BMS_MODE_CANFD);
    end
  endfunction

  // Resolve one select field: key check, unbonded substitution, disable
  // Order matters: a bad key overrides all, and a disabled field is kept
  // even though 0xff would otherwise look like an unbonded pin.
  function [7:0] resolve;
    input       key_ok;
    input [7:0] field;
    input [7:0] dflt;
    input       bonded;
    begin
      if (!key_ok)
        resolve = dflt;
      else if (field == `BMS_PIN_DISABLED)
        resolve = `BMS_PIN_DISABLED;
      else if (!bonded)
        resolve = dflt;
      else
        resolve = field;
    end
  endfunction

  // Two-stage synchronisers for pins, the debugger strap and the security release
  // The whole pin bank is synchronised so any GPIO can act as a select pin;
  // that costs two flops per GPIO, traded for a plain indexed lookup.
  // Only the second stage is read; the first may still be settling.
  reg [NGPIO-1:0] gpio_s1_q;
  reg [NGPIO-1:0] gpio_s2_q;
  reg             dbg_s1_q;
  reg             dbg_s2_q;
  reg             rel_s1_q;
  reg             rel_s2_q;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gpio_s1_q <= {NGPIO{1'b0}};
      gpio_s2_q <= {NGPIO{1'b0}};
      dbg_s1_q  <= 1'b0;
      dbg_s2_q  <= 1'b0;
      rel_s1_q  <= 1'b0;
      rel_s2_q  <= 1'b0;
    end else begin
      gpio_s1_q <= gpio_in;
      gpio_s2_q <= gpio_s1_q;
      dbg_s1_q  <= debugger_attached;
      dbg_s2_q  <= dbg_s1_q;
      rel_s1_q  <= sec_release;
      rel_s2_q  <= rel_s1_q;
    end
  end

  // Registers and decision state
  reg [31:0] emu_pin_select_config_q;
  reg [31:0] emu_boot_table_low_q;
  reg [31:0] emu_boot_table_high_q;
  reg        start_q;
  reg        ldr_done_q;
  reg [3:0]  state_q;
  reg [3:0]  state_d;
  // Settle counter, loaded in ANALOG and run down in SETTLE
  reg [7:0]  cnt_q;
  // Captured configuration, held from CONFIG until the next reset
  reg        emu_q;
  reg [7:0]  pin_q [0:2];
  reg [63:0] table_q;
  // Index and entry, captured once per boot and held until reset
  reg [2:0]  index_q;
  reg [7:0]  entry_q;
  reg [1:0]  npins_q;

  // Source select: emulation registers only when debug and enabled
  // The OTP words and the enable strap are static after reset: no synchroniser
  wire        emu_path = dbg_s2_q & otp_emu_boot_en;
  wire [31:0] cfg_w    = emu_path ? emu_pin_select_config_q : otp_pin_cfg;
  wire [63:0] tbl_w    = emu_path ? {emu_boot_table_high_q, emu_boot_table_low_q}
                                  : {otp_tbl_hi, otp_tbl_lo};
  wire        key_ok   = (cfg_w[`BMS_KEY_MSB:`BMS_KEY_LSB] == `BMS_KEY_VALUE);
  // Without a key the factory table must go with the factory pins
  wire [63:0] tbl_sel  = key_ok ? tbl_w : `BMS_DEF_TABLE;

  // Factory pins; pin 2 has none and stays disabled
  wire [7:0] def_pin [0:2];
  assign def_pin[0] = `BMS_DEF_PIN0;
  assign def_pin[1] = `BMS_DEF_PIN1;
  assign def_pin[2] = `BMS_DEF_PIN2;

  // Per-pin resolution, sampled bit and analog handling
  // Each select pin is resolved the same way, so the logic repeats per pin
  wire [7:0] res_w  [0:2];
  wire [2:0] en_w;
  wire [2:0] bit_w;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin
      wire [7:0] fld = cfg_w[8*g+7:8*g];
      // Bonding of the GPIO that this field names
      wire       fld_bonded = gpio_bonded[fld];
      // Pin 2 has no factory pin, so an unbonded choice disables it instead
      assign res_w[g] = (g == 2 && key_ok && fld != `BMS_PIN_DISABLED
                         && !fld_bonded)
                        ? `BMS_PIN_DISABLED
                        : resolve(key_ok, fld, def_pin[g], fld_bonded);
      assign en_w[g]  = (pin_q[g] != `BMS_PIN_DISABLED);
      // A disabled pin reads as zero, whatever GPIO 255 shows
      assign bit_w[g] = en_w[g] & gpio_s2_q[pin_q[g]];
    end
  endgenerate

  // No enabled pin skips the settle wait and keeps the index at zero
  wire       any_en = |en_w;
  wire [3:0] ent_mode = entry_q[3:0];

  // Sequencer next state
  // LOADER waits on software with no time limit; the watchdog is off then,
  // so a hung loader is left to the debugger or the security subsystem.
  always @* begin
    state_d = state_q;
    case (state_q)
      S_HOLD:   if (rel_s2_q) state_d = S_CONFIG;
      S_CONFIG: if (start_q) state_d = S_ANALOG;
      S_ANALOG: state_d = any_en ? S_SETTLE : S_DECODE;
      // The wait lasts SETTLE_CYC+1 cycles, the zero cycle included
      S_SETTLE: if (cnt_q == 8'h00) state_d = S_SAMPLE;
      S_SAMPLE: state_d = S_DECODE;
      S_DECODE: state_d = S_WDOG;
      S_WDOG:   state_d = S_LOADER;
      S_LOADER: if (ldr_done_q) state_d = S_CLOSE;
      S_CLOSE:  state_d = S_JUMP;
      S_JUMP:   state_d = S_JUMP;
      // An unknown code returns to HOLD, so it can never skip the release
      default:  state_d = S_HOLD;
    endcase
  end

  // Sequencer, pin capture and decode
  // Every top-level output but reg_rdata leaves a flop here; the decision outputs are
  // written only in DECODE and WDOG, which keeps them stable once published.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q            <= S_HOLD;
      cnt_q              <= 8'h00;
      emu_q              <= 1'b0;
      pin_q[0]           <= `BMS_PIN_DISABLED;
      pin_q[1]           <= `BMS_PIN_DISABLED;
      pin_q[2]           <= `BMS_PIN_DISABLED;
      table_q            <= 64'h0000_0000_0000_0000;
      index_q            <= 3'h0;
      npins_q            <= 2'h0;
      entry_q            <= 8'h00;
      cpu_reset_n        <= 1'b0;
      wdog_enable        <= 1'b0;
      loader_run         <= 1'b0;
      ram_access_window  <= 1'b0;
      app_jump           <= 1'b0;
      boot_mode          <= 4'h0;
      boot_option        <= 4'h0;
      decision_valid     <= 1'b0;
      analog_mode_select <= 3'h7;
    end else begin
      state_q <= state_d;
      case (state_q)
        // Release opens the CPU, watchdog and RAM window together
        S_HOLD: begin
          if (rel_s2_q) begin
            cpu_reset_n       <= 1'b1;
            wdog_enable       <= 1'b1;
            ram_access_window <= 1'b1;
          end
        end
        // Sources and table are copied once, at the start edge,
        // so later register writes cannot move the decision
        S_CONFIG: begin
          if (start_q) begin
            emu_q    <= emu_path;
            pin_q[0] <= res_w[0];
            pin_q[1] <= res_w[1];
            pin_q[2] <= res_w[2];
            table_q  <= tbl_sel;
          end
        end
        S_ANALOG: begin
          // Digital mode only for pins actually used
          analog_mode_select <= ~en_w;
          cnt_q              <= SETTLE_CYC;
          index_q            <= 3'h0;
          npins_q            <= 2'h0;
        end
        S_SETTLE: cnt_q <= cnt_q - 8'h01;
        // Single capture: later pin changes cannot move the index
        S_SAMPLE: begin
          index_q <= bit_w;
          npins_q <= {1'b0, en_w[0]} + {1'b0, en_w[1]} + {1'b0, en_w[2]};
        end
        // Entry n is the byte at bits 8n+7:8n of the copied table
        S_DECODE: begin
          entry_q        <= table_q[8*index_q +: 8];
          decision_valid <= 1'b0;
        end
        // Fallback follows the path taken, not the raw debugger strap
        S_WDOG: begin
          wdog_enable    <= 1'b0;
          boot_option    <= entry_q[7:4];
          decision_valid <= 1'b1;
          if (supported(ent_mode))
            boot_mode <= ent_mode;
          else
            boot_mode <= emu_q ? `BMS_MODE_WAIT : `BMS_MODE_FLASH;
          loader_run <= 1'b1;
        end
        // Ending steps then follow one cycle apart
        S_LOADER: if (ldr_done_q) loader_run <= 1'b0;
        S_CLOSE:  ram_access_window <= 1'b0;
        // Jump is held until reset; there is no way back into the sequence
        S_JUMP:   app_jump <= 1'b1;
        default:  ;
      endcase
    end
  end

  // Read words assembled outside the port process
  wire [31:0] status_w = {20'h0,
                          npins_q,        // Bits 11:10
                          emu_q,          // Bit 9
                          decision_valid, // Bit 8
                          state_q,        // Bits 7:4
                          1'b0,
                          index_q};       // Bits 2:0
  wire [31:0] result_w = {16'h0,
                          entry_q,        // Bits 15:8
                          boot_option,    // Bits 7:4
                          boot_mode};     // Bits 3:0
  wire [31:0] ctrl_w   = {30'h0, ldr_done_q, start_q};

  // Register map, byte offsets:
  //   0x00 emulation pin select word, RW
  //   0x04 emulation boot table low word, RW
  //   0x08 emulation boot table high word, RW
  //   0x0c control: bit 0 start, bit 1 loader done
  //   0x10 status: pin count, path, decision flag, state, index, RO
  //   0x14 result: entry, option, mode, RO
  // Unmapped reads return zero and unmapped writes are dropped.
  // Register port; emulation registers writable any time, read data one cycle later
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      emu_pin_select_config_q <= 32'h0000_0000;
      emu_boot_table_low_q    <= 32'h0000_0000;
      emu_boot_table_high_q   <= 32'h0000_0000;
      start_q                 <= 1'b0;
      ldr_done_q              <= 1'b0;
      reg_rdata               <= 32'h0000_0000;
    end else begin
      // Writes land in any state; only CONFIG and LOADER act on the control bits
      if (reg_wr) begin
        case (reg_addr)
          `BMS_OFF_EMU_PIN_CFG: emu_pin_select_config_q <= reg_wdata;
          `BMS_OFF_EMU_TBL_LO:  emu_boot_table_low_q    <= reg_wdata;
          `BMS_OFF_EMU_TBL_HI:  emu_boot_table_high_q   <= reg_wdata;
          // Both control bits are levels, so each control write sets both
          `BMS_OFF_CTRL: begin
            start_q    <= reg_wdata[`BMS_CTRL_START];
            ldr_done_q <= reg_wdata[`BMS_CTRL_LDR_DONE];
          end
          default: ;
        endcase
      end
      // Read data stands for one cycle, then returns to zero
      if (reg_rd) begin
        case (reg_addr)
          `BMS_OFF_EMU_PIN_CFG: reg_rdata <= emu_pin_select_config_q;
          `BMS_OFF_EMU_TBL_LO:  reg_rdata <= emu_boot_table_low_q;
          `BMS_OFF_EMU_TBL_HI:  reg_rdata <= emu_boot_table_high_q;
          `BMS_OFF_CTRL:        reg_rdata <= ctrl_w;
          `BMS_OFF_STATUS:      reg_rdata <= status_w;
          `BMS_OFF_RESULT:      reg_rdata <= result_w;
          default:              reg_rdata <= 32'h0000_0000;
        endcase
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

endmodule // bms_top

// ===== sim/bms_top_sva.sv
// Checker for the boot mode selector: ending steps, release and decision.
// Assumes it is bound to bms_top and sees only its ports.
`timescale 1ns/1ns
module bms_chk (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        sec_release,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        cpu_reset_n,
  input wire logic        wdog_enable,
  input wire logic        loader_run,
  input wire logic        ram_access_window,
  input wire logic        app_jump,
  input wire logic [3:0]  boot_mode,
  input wire logic [3:0]  boot_option,
  input wire logic        decision_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Last two boot steps, each given a short bound
  sequence s_close_jump;
    ##[0:8] !ram_access_window ##[0:8] app_jump;
  endsequence
  AST_CPU_RELEASE: assert property ($rose(cpu_reset_n) |-> $past(sec_release, 2))
    else $error("cpu released without a release request");
  AST_WDOG_OFF_LOADER: assert property ($rose(loader_run) |-> !wdog_enable && decision_valid)
    else $error("loader started with watchdog on or no decision");
  AST_LOADER_WINDOW: assert property (loader_run |-> ram_access_window && cpu_reset_n)
    else $error("loader running with ram window closed");
  AST_END_STEPS: assert property ($fell(loader_run) |-> s_close_jump)
    else $error("window close and jump missing after loader");
  AST_JUMP_ORDER: assert property ($rose(app_jump) |-> !ram_access_window && !loader_run)
    else $error("jump before window closed");
  AST_JUMP_HOLD: assert property (app_jump |=> app_jump && !ram_access_window)
    else $error("jump not held");
  AST_MODE_RANGE: assert property (decision_valid |-> boot_mode <= 4'h8)
    else $error("unsupported boot mode reported");
  AST_DECISION_HELD: assert property (decision_valid |=> decision_valid && $stable(boot_mode)
    && $stable(boot_option))
    else $error("decision changed after it was made");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule // bms_chk

// ===== sim/bms_far_side.sv
// Far side model: select pin levels and package bonding.
// Assumes the bench names the three realized select GPIOs and their levels.
`timescale 1ns/1ns
module bms_far_side (
  input  wire logic         mclk,
  input  wire logic [7:0]   s0,
  input  wire logic [7:0]   s1,
  input  wire logic [7:0]   s2,
  input  wire logic [2:0]   lvl,
  output logic      [255:0] gpio_in,
  output logic      [255:0] gpio_bonded
);
  logic [255:0] bg = 256'h0;
  // Unused pins toggle so a wrongly chosen pin never reads a steady level
  always @(posedge mclk) bg <= ~bg;
  always_comb begin
    gpio_in = bg;
    gpio_in[s2] = lvl[2];
    gpio_in[s1] = lvl[1];
    gpio_in[s0] = lvl[0];
  end
  // GPIO 250 and above are not bonded out
  assign gpio_bonded = {6'h00, {250{1'b1}}};
endmodule // bms_far_side

// ===== sim/boot_mode_selector_test.sv
// Self-checking bench for bms_top: random boots against a behavioural model.
// Assumes bms_top, bms_far_side and bms_chk are compiled before this file.
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got=%h exp=%h", $time, g, e); end end
module boot_mode_selector_test;
  logic        mclk = 0, resetn = 0, sec_release = 0, reg_wr = 0, reg_rd = 0;
  logic        otp_emu_boot_en = 0, debugger_attached = 0;
  logic [31:0] otp_pin_cfg = 0, otp_tbl_lo = 0, otp_tbl_hi = 0, reg_wdata = 0;
  logic [31:0] reg_rdata, rd_val;
  logic [7:0]  reg_addr = 0, s0 = 8'hff, s1 = 8'hff, s2 = 8'hff;
  logic [2:0]  lvl = 0, analog_mode_select;
  logic [255:0] gpio_in, gpio_bonded;
  logic        cpu_reset_n, wdog_enable, loader_run, ram_access_window, app_jump;
  logic [3:0]  boot_mode, boot_option;
  logic        decision_valid;
  int          failures = 0, total_checks = 0, cycles = 0;

  bms_far_side i_bms_far_side (.mclk, .s0, .s1, .s2, .lvl, .gpio_in, .gpio_bonded);
  bms_top i_bms_top (.mclk, .resetn, .gpio_in, .gpio_bonded, .otp_pin_cfg, .otp_tbl_lo,
    .otp_tbl_hi, .otp_emu_boot_en, .debugger_attached, .sec_release, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .analog_mode_select, .cpu_reset_n,
    .wdog_enable, .loader_run, .ram_access_window, .app_jump, .boot_mode,
    .boot_option, .decision_valid);

  always #20 mclk = ~mclk;
  // Hang guard: a boot takes well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      give_verdict();
    end
  end

  task give_verdict;
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Register port: one-cycle strobes, read data in the following cycle
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // Bounded wait for release, decision or jump
  task wait_on(input int w);
    bit hit;
    hit = 1'b0;
    for (int n = 0; n < 300 && !hit; n++) begin
      @(posedge mclk);
      #1;
      hit = (w == 0 && cpu_reset_n === 1'b1) || (w == 1 && decision_valid === 1'b1)
          || (w == 2 && app_jump === 1'b1);
    end
    // A wait that runs out counts as a mismatch
    if (!hit) failures++;
  endtask
  // Random select pin in a private range, or unbonded, or disabled
  function automatic logic [7:0] pick(input int k, input int i);
    int r;
    r = $urandom % 56;
    // Pin 2 is disabled first in every third boot
    if (i == 1 || (k == 2 && i % 3 == 0) || $urandom % 4 == 0) return 8'hff;
    if (r >= 50) return 8'(250 + k);
    // Ranges 0..49, 100..149 and 200..249 never meet the default pins 72 and 84
    return 8'(k * 100 + r);
  endfunction

  task boot(input int i);
    logic [31:0] cfg, lo, hi;
    logic [63:0] tbl;
    logic [7:0]  p0, p1, p2, ent;
    logic [2:0]  en, idx;
    logic [3:0]  m;
    logic        emu;
    cfg = {(i == 0 || $urandom % 8 == 0) ? 8'h3c : 8'h5a, pick(2, i), pick(1, i), pick(0, i)};
    lo = $urandom;
    hi = $urandom;
    emu = $urandom % 2 && i != 2;
    // Mid-run resets start on a rising edge like every other input change
    if (i != 0) @(posedge mclk);
    resetn <= 1'b0;
    sec_release <= 1'b0;
    debugger_attached <= emu | (i != 2 && $urandom % 2 == 1);
    otp_emu_boot_en <= emu | (i == 2);
    otp_pin_cfg <= emu ? $urandom : cfg;
    otp_tbl_lo <= emu ? $urandom : lo;
    otp_tbl_hi <= emu ? $urandom : hi;
    // Model: key, unbonded substitution, index and fallback
    tbl = {hi, lo};
    {p2, p1, p0} = cfg[23:0];
    p0 = (p0 != 8'hff && p0 >= 8'd250) ? 8'h54 : p0;
    p1 = (p1 != 8'hff && p1 >= 8'd250) ? 8'h48 : p1;
    p2 = (p2 >= 8'd250) ? 8'hff : p2;
    if (cfg[31:24] != 8'h5a) begin
      {p2, p1, p0} = 24'hff_48_54;
      tbl = 64'h0302_0100;
    end
    en = {p2 != 8'hff, p1 != 8'hff, p0 != 8'hff};
    lvl <= $urandom;
    {s2, s1, s0} <= {p2, p1, p0};
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    idx = en & lvl;
    ent = tbl[8 * idx +: 8];
    m = ent[3:0] > 4'h8 ? (emu ? 4'h4 : 4'h3) : ent[3:0];
    `CHK(analog_mode_select, 3'b111)
    rd(8'h00);
    `CHK(rd_val, 32'h0)
    @(posedge mclk);
    sec_release <= 1'b1;
    wait_on(0);
    `CHK({cpu_reset_n, wdog_enable, ram_access_window}, 3'b111)
    wr(8'h00, emu ? cfg : $urandom);
    wr(8'h04, emu ? lo : $urandom);
    wr(8'h08, emu ? hi : $urandom);
    rd(8'h00);
    if (emu) `CHK(rd_val, cfg)
    wr(8'h0c, 32'h1);
    wait_on(1);
    `CHK(boot_mode, m)
    `CHK(boot_option, ent[7:4])
    `CHK({wdog_enable, loader_run}, 2'b01)
    `CHK(analog_mode_select, ~en)
    rd(8'h10);
    `CHK(rd_val[2:0], idx)
    `CHK(rd_val[11:8], {2'($countones(en)), emu, 1'b1})
    rd(8'h14);
    `CHK(rd_val[7:0], {ent[7:4], m})
    `CHK(rd_val[15:8], ent)
    rd(8'h3c);
    `CHK(rd_val, 32'h0)
    lvl <= ~lvl;
    wr(8'h0c, 32'h2);
    wait_on(2);
    `CHK({app_jump, ram_access_window, loader_run}, 3'b100)
    `CHK(boot_mode, m)
  endtask

  initial begin
    void'($urandom(32'ha53c));
    for (int i = 0; i < 24; i++) boot(i);
    give_verdict();
  end
endmodule // boot_mode_selector_test

bind bms_top bms_chk i_bms_chk (.mclk, .resetn, .sec_release, .reg_rd, .reg_rdata,
  .cpu_reset_n, .wdog_enable, .loader_run, .ram_access_window, .app_jump, .boot_mode,
  .boot_option, .decision_valid);
